// ### lsq_map.svh
`ifndef LSQ_MAP_SVH
`define LSQ_MAP_SVH

// Register byte offsets
`define LSQ_CMD 12'h000
`define LSQ_ARG0 12'h004
`define LSQ_ARG1 12'h008
`define LSQ_STAT 12'h00c
`define LSQ_VPTS 12'h010
`define LSQ_DPTS 12'h014
`define LSQ_RBND 12'h018
`define LSQ_RES 12'h01c
`define LSQ_SDUR 12'h020
`define LSQ_TRIG 12'h024
`define LSQ_WAIT 12'h028
`define LSQ_QST 12'h02c
`define LSQ_SCNT 12'h030
`define LSQ_ERR 12'h034
// Sixteen-word value window and eight-word sample table bases
`define LSQ_WIN_PAGE 6'h01
`define LSQ_SMP_PAGE 7'h04

// Field positions
`define LSQ_POL_BIT 0
`define LSQ_RES_LSB 0

// Reset values
`define LSQ_RES_RST 2'h0
`define LSQ_WAIT_RST 16'h0000

// Resolution selections and point capacities
`define LSQ_RES_MIN 2'h0
`define LSQ_RES_MAX 2'h1
`define LSQ_RES_LOW 2'h2
`define LSQ_PTS_MIN 13'hf5d
`define LSQ_PTS_MAX 13'h170c
`define LSQ_PTS_LOW 13'hb86

// Timing limits in microseconds and the clock
`define LSQ_DWELL_MIN_US 16'h005d
`define LSQ_DWELL_MAX_US 16'h84d0
`define LSQ_PULSE_MIN_US 16'h00fa
`define LSQ_PULSE_MAX_US 16'h84d0
`define LSQ_CLK_NS 8
`define LSQ_NS_PER_US 1000

// Averaging bounds and sample-type letters
`define LSQ_AVG_MIN 9'h002
`define LSQ_AVG_MAX 9'h100
`define LSQ_ASCII_V 8'h56
`define LSQ_ASCII_C 8'h43

// Error codes, 16-bit two's complement
`define LSQ_E_CMD 16'hff9c
`define LSQ_E_CONF 16'hff23
`define LSQ_E_MUCH 16'hff21
`define LSQ_E_LEN 16'hff1e

`endif

// ### lsq_pkg.sv
package lsq_pkg;

   // Command codes written to the command register
   typedef enum logic [3:0] {
      OP_NOP, OP_CLEAR, OP_VOLT, OP_CURR, OP_DWELL, OP_SAMP_V,
      OP_SAMP_C, OP_SET_SAMP, OP_SET_TRIG, OP_SET_WAIT, OP_TRIG,
      OP_RUN
   } lsq_op_t;

   // Sequencer states
   typedef enum logic [1:0] {ST_IDLE, ST_FILL, ST_RUN} lsq_st_t;

endpackage

// ### lsq_sequencer.sv
`timescale 1ns/1ps
`include "lsq_map.svh"

module lsq_sequencer #(
   parameter int VW = 16,
   parameter int MAXP = 5900,
   parameter int NSMP = 8,
   parameter int EQD = 8,
   parameter int CYC_PER_US = `LSQ_NS_PER_US / `LSQ_CLK_NS
) (
   // Clock and reset
   input wire logic mclk,
   input wire logic rst_n,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Output stage
   input wire logic output_off,
   output logic [VW-1:0] level_out,
   output logic list_running,
   output logic flag_collector_on
);
   localparam int AW = $clog2(MAXP + 1);
   localparam int QW = $clog2(EQD + 1);
   localparam int PW = $clog2(CYC_PER_US);

   ////////////////////////////////////////////////////////////////////
   logic pready_r, pslverr_r, lvl_dummy;
   logic [31:0] prdata_r, rd_data, arg0_r, arg1_r;
   logic [VW-1:0] val_mem [MAXP];
   logic [15:0] dwl_mem [MAXP];
   logic trg_mem [MAXP];
   logic [AW-1:0] val_cnt_r, dwl_cnt_r, qst_r, cap, widx, run_idx_r;
   logic [AW-1:0] smp_idx_r [NSMP];
   logic [AW:0] pts_sum;
   logic [3:0] smp_cnt_r;
   logic [1:0] res_r;
   logic [15:0] samp_us_r, trig_us_r, wait_us_r, cmd_err, rd_err;
   logic [15:0] push_code, us_left_r, pls_left_r, dw_data;
   logic [15:0] eq_mem [EQD];
   logic [QW-1:0] eq_n_r;
   logic [$clog2(EQD)-1:0] eq_wp_r, eq_rp_r;
   logic [PW-1:0] pre_r;
   logic [8:0] avg, fill_left_r;
   logic [VW-1:0] fill_val_r, vw_data, level_r;
   logic samp_set_r, trig_set_r, trig_pol_r, trig_mode_r, list_curr_r;
   logic smp_curr_r, lstep_r, lval_r, off_s1_r, off_s2_r, flag_r;
   logic pend, wr_go, rd_go, cmd_go, cmd_ok, push, pop, tick, vw_trg;
   logic vw_en, dw_en, samp_op, win_hit, smp_hit, expire, run_go;
   lsq_pkg::lsq_op_t op;
   lsq_pkg::lsq_st_t st_r;

   ////////////////////////////////////////////////////////////////////
   // Capacity for a resolution selection, never beyond the table
   function automatic logic [AW-1:0] cap_of(input logic [1:0] r);
      logic [12:0] c;
      c = (r == `LSQ_RES_MAX) ? `LSQ_PTS_MAX :
          (r == `LSQ_RES_LOW) ? `LSQ_PTS_LOW : `LSQ_PTS_MIN;
      if (c > 13'(MAXP))
         c = 13'(MAXP);
      return AW'(c);
   endfunction

   // Floor to a power of two between 2 and 256
   function automatic logic [8:0] avg_of(input logic [15:0] v);
      logic [8:0] a;
      a = `LSQ_AVG_MIN;
      if (v > 16'h00ff)
         a = `LSQ_AVG_MAX;
      else
         for (int i = 2; i < 8; i++)
            if (v[i])
               a = 9'(1 << i);
      return a;
   endfunction

   // Inclusive range test on microsecond values
   function automatic logic in_rng(input logic [15:0] v,
                                   input logic [15:0] lo,
                                   input logic [15:0] hi);
      return (v >= lo) && (v <= hi);
   endfunction

   ////////////////////////////////////////////////////////////////////
   // Bus decode
   assign win_hit = paddr[11:6] == `LSQ_WIN_PAGE;
   assign smp_hit = paddr[11:5] == `LSQ_SMP_PAGE && 32'(paddr[4:2]) < NSMP;
   assign pend = psel && penable && !pready_r && st_r != lsq_pkg::ST_FILL;
   assign wr_go = psel && penable && pready_r && pwrite && !pslverr_r;
   assign rd_go = psel && penable && pready_r && !pwrite && !pslverr_r;
   assign cmd_go = wr_go && paddr == `LSQ_CMD;
   assign op = lsq_pkg::lsq_op_t'(pwdata[3:0]);
   assign cap = cap_of(res_r);
   assign avg = avg_of(arg0_r[15:0]);
   assign pts_sum = {1'b0, val_cnt_r} + (AW+1)'(avg);
   assign samp_op = op == lsq_pkg::OP_SAMP_V || op == lsq_pkg::OP_SAMP_C;
   assign widx = qst_r + AW'(paddr[5:2]);
   assign tick = pre_r == '0;
   assign pready = pready_r;
   assign pslverr = pslverr_r;
   assign prdata = prdata_r;
   assign level_out = level_r;
   assign list_running = lvl_dummy;
   assign flag_collector_on = flag_r;

   // Register read mux
   always_comb
   begin
      rd_data = '0;
      if (win_hit)
         rd_data = widx < val_cnt_r ? 32'(val_mem[widx]) : '0;
      else if (smp_hit)
         rd_data = 32'(smp_idx_r[paddr[4:2]]);
      else
         unique case (paddr)
            `LSQ_ARG0: rd_data = arg0_r;
            `LSQ_ARG1: rd_data = arg1_r;
            `LSQ_STAT: rd_data = {25'h0, eq_n_r != '0, trig_mode_r,
               trig_set_r, samp_set_r, list_curr_r, st_r};
            `LSQ_VPTS: rd_data = 32'(val_cnt_r);
            `LSQ_DPTS: rd_data = 32'(dwl_cnt_r);
            `LSQ_RBND: rd_data = res_r == `LSQ_RES_MAX ?
               {`LSQ_DWELL_MIN_US, `LSQ_DWELL_MAX_US} :
               {`LSQ_DWELL_MAX_US, `LSQ_DWELL_MIN_US};
            `LSQ_RES: rd_data = {14'h0, res_r, 3'h0, cap};
            `LSQ_SDUR: rd_data = 32'(samp_us_r);
            `LSQ_TRIG: rd_data = {15'h0, trig_pol_r, trig_us_r};
            `LSQ_WAIT: rd_data = 32'(wait_us_r);
            `LSQ_QST: rd_data = 32'(qst_r);
            `LSQ_SCNT: rd_data = {16'h0, smp_curr_r ? `LSQ_ASCII_C :
               `LSQ_ASCII_V, 4'h0, smp_cnt_r};
            `LSQ_ERR: rd_data = eq_n_r != '0 ?
               {{16{eq_mem[eq_rp_r][15]}}, eq_mem[eq_rp_r]} : '0;
            default: rd_data = '0;
         endcase
   end

   // APB handshake: outside sample fills, answer one cycle after the access phase opens
   always_ff @(posedge mclk)
   begin
      if (!rst_n)
      begin
         pready_r <= 1'b0;
         pslverr_r <= 1'b0;
         prdata_r <= '0;
      end
      else
      begin
         pready_r <= pend;
         pslverr_r <= pend && !(win_hit || smp_hit || paddr <= `LSQ_ERR);
         if (pend)
            prdata_r <= rd_data;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Command check: one error code or zero
   always_comb
   begin
      cmd_err = '0;
      if (cmd_go)
      begin
         if (st_r != lsq_pkg::ST_IDLE)
            cmd_err = `LSQ_E_CMD;
         else
            unique case (op)
               lsq_pkg::OP_NOP, lsq_pkg::OP_CLEAR:
               begin
               end
               lsq_pkg::OP_VOLT, lsq_pkg::OP_CURR:
                  if (val_cnt_r != '0 &&
                      list_curr_r != (op == lsq_pkg::OP_CURR))
                     cmd_err = `LSQ_E_CONF;
                  else if (val_cnt_r >= cap)
                     cmd_err = `LSQ_E_MUCH;
               lsq_pkg::OP_DWELL:
                  if (!in_rng(arg0_r[15:0], `LSQ_DWELL_MIN_US,
                              `LSQ_DWELL_MAX_US))
                     cmd_err = `LSQ_E_CMD;
                  else if (dwl_cnt_r >= cap)
                     cmd_err = `LSQ_E_MUCH;
               lsq_pkg::OP_SAMP_V, lsq_pkg::OP_SAMP_C:
                  if (!samp_set_r)
                     cmd_err = `LSQ_E_CONF;
                  else if (!lstep_r)
                     cmd_err = `LSQ_E_CONF;
                  else if (dwl_cnt_r != val_cnt_r)
                     cmd_err = `LSQ_E_LEN;
                  else if (32'(smp_cnt_r) >= NSMP)
                     cmd_err = `LSQ_E_MUCH;
                  else if (pts_sum > (AW+1)'(`LSQ_PTS_MIN) ||
                           pts_sum > (AW+1)'(cap))
                     cmd_err = `LSQ_E_MUCH;
               lsq_pkg::OP_SET_SAMP:
                  if (samp_set_r)
                     cmd_err = `LSQ_E_CMD;
                  else if (!in_rng(arg0_r[15:0], `LSQ_PULSE_MIN_US,
                                   `LSQ_PULSE_MAX_US))
                     cmd_err = `LSQ_E_CMD;
               lsq_pkg::OP_SET_TRIG, lsq_pkg::OP_SET_WAIT:
                  if (!in_rng(arg0_r[15:0], `LSQ_PULSE_MIN_US,
                              `LSQ_PULSE_MAX_US))
                     cmd_err = `LSQ_E_CMD;
               lsq_pkg::OP_TRIG:
                  if (!trig_set_r || !lval_r)
                     cmd_err = `LSQ_E_CONF;
                  else if (dwl_cnt_r != val_cnt_r)
                     cmd_err = `LSQ_E_LEN;
                  else if (val_cnt_r >= cap)
                     cmd_err = `LSQ_E_MUCH;
               lsq_pkg::OP_RUN:
                  if (val_cnt_r == '0 || dwl_cnt_r == '0)
                     cmd_err = `LSQ_E_CONF;
               default: cmd_err = `LSQ_E_CMD;
            endcase
      end
   end

   // Errors posted by reads of unset settings or the wrong list type
   always_comb
   begin
      rd_err = '0;
      if (rd_go && paddr == `LSQ_SDUR && !samp_set_r)
         rd_err = `LSQ_E_CMD;
      else if (rd_go && paddr == `LSQ_TRIG && !trig_set_r)
         rd_err = `LSQ_E_CMD;
      else if (rd_go && win_hit && list_curr_r && val_cnt_r != '0)
         rd_err = `LSQ_E_CONF;
   end

   assign cmd_ok = cmd_go && cmd_err == '0;
   assign push_code = cmd_err | rd_err;
   assign push = push_code != '0;
   assign pop = rd_go && paddr == `LSQ_ERR && eq_n_r != '0;

   ////////////////////////////////////////////////////////////////////
   // Error queue; a full queue drops the newest code
   always_ff @(posedge mclk)
   begin
      if (!rst_n)
      begin
         eq_wp_r <= '0;
         eq_rp_r <= '0;
         eq_n_r <= '0;
      end
      else
      begin
         if (push && 32'(eq_n_r) < EQD)
         begin
            eq_mem[eq_wp_r] <= push_code;
            eq_wp_r <= eq_wp_r + 1'b1;
         end
         if (pop)
            eq_rp_r <= eq_rp_r + 1'b1;
         eq_n_r <= eq_n_r + QW'(push && 32'(eq_n_r) < EQD) - QW'(pop);
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Settings written by software
   always_ff @(posedge mclk)
   begin
      if (!rst_n)
      begin
         arg0_r <= '0;
         arg1_r <= '0;
         qst_r <= '0;
         res_r <= `LSQ_RES_RST;
         samp_set_r <= 1'b0;
         samp_us_r <= '0;
         trig_set_r <= 1'b0;
         trig_mode_r <= 1'b0;
         trig_us_r <= '0;
         trig_pol_r <= 1'b0;
         wait_us_r <= `LSQ_WAIT_RST;
         lstep_r <= 1'b0;
         lval_r <= 1'b0;
      end
      else
      begin
         if (wr_go && paddr == `LSQ_ARG0)
            arg0_r <= pwdata;
         if (wr_go && paddr == `LSQ_ARG1)
            arg1_r <= pwdata;
         if (wr_go && paddr == `LSQ_QST)
            qst_r <= pwdata[AW-1:0];
         if (wr_go && paddr == `LSQ_RES && st_r == lsq_pkg::ST_IDLE)
            res_r <= pwdata[`LSQ_RES_LSB+:2];
         if (cmd_go)
         begin
            lstep_r <= cmd_ok && (op == lsq_pkg::OP_VOLT ||
               op == lsq_pkg::OP_CURR || op == lsq_pkg::OP_SET_SAMP);
            lval_r <= cmd_ok && (op == lsq_pkg::OP_VOLT ||
               op == lsq_pkg::OP_CURR);
         end
         if (cmd_ok && op == lsq_pkg::OP_SET_SAMP)
         begin
            samp_set_r <= 1'b1;
            samp_us_r <= arg0_r[15:0];
         end
         if (cmd_ok && op == lsq_pkg::OP_SET_TRIG)
         begin
            trig_set_r <= 1'b1;
            trig_mode_r <= 1'b1;
            trig_us_r <= arg0_r[15:0];
            trig_pol_r <= arg1_r[`LSQ_POL_BIT];
         end
         if (cmd_ok && op == lsq_pkg::OP_SET_WAIT)
            wait_us_r <= arg0_r[15:0];
         if (cmd_ok && op == lsq_pkg::OP_CLEAR)
         begin
            samp_set_r <= 1'b0;
            trig_set_r <= 1'b0;
            trig_mode_r <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Table writes: step entries, dwell entries and sample fills
   assign vw_en = st_r == lsq_pkg::ST_FILL || (cmd_ok &&
      (op == lsq_pkg::OP_VOLT || op == lsq_pkg::OP_CURR ||
       op == lsq_pkg::OP_TRIG));
   assign vw_data = st_r == lsq_pkg::ST_FILL ? fill_val_r : arg0_r[VW-1:0];
   assign vw_trg = st_r != lsq_pkg::ST_FILL && op == lsq_pkg::OP_TRIG;
   assign dw_en = st_r == lsq_pkg::ST_FILL ||
      (cmd_ok && op == lsq_pkg::OP_DWELL);
   assign dw_data = st_r == lsq_pkg::ST_FILL ? samp_us_r : arg0_r[15:0];

   // Storage, addressed by the next free location
   always_ff @(posedge mclk)
   begin
      if (vw_en)
      begin
         val_mem[val_cnt_r] <= vw_data;
         trg_mem[val_cnt_r] <= vw_trg;
      end
      if (dw_en)
         dwl_mem[dwl_cnt_r] <= dw_data;
   end

   // Fill pointers, list type and the sample table
   always_ff @(posedge mclk)
   begin
      if (!rst_n)
      begin
         val_cnt_r <= '0;
         dwl_cnt_r <= '0;
         list_curr_r <= 1'b0;
         smp_cnt_r <= '0;
         smp_curr_r <= 1'b0;
      end
      else if (cmd_ok && op == lsq_pkg::OP_CLEAR)
      begin
         val_cnt_r <= '0;
         dwl_cnt_r <= '0;
         list_curr_r <= 1'b0;
         smp_cnt_r <= '0;
      end
      else
      begin
         if (vw_en)
            val_cnt_r <= val_cnt_r + 1'b1;
         if (dw_en)
            dwl_cnt_r <= dwl_cnt_r + 1'b1;
         if (cmd_ok && (op == lsq_pkg::OP_VOLT || op == lsq_pkg::OP_CURR))
            list_curr_r <= op == lsq_pkg::OP_CURR;
         if (cmd_ok && samp_op)
         begin
            smp_idx_r[smp_cnt_r[2:0]] <= val_cnt_r == '0 ? '0 :
               val_cnt_r - 1'b1;
            smp_cnt_r <= smp_cnt_r + 1'b1;
            smp_curr_r <= op == lsq_pkg::OP_SAMP_C;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Sequencer: sample fills and list execution
   assign run_go = cmd_ok && op == lsq_pkg::OP_RUN;
   assign expire = st_r == lsq_pkg::ST_RUN && tick && us_left_r <= 16'h0001;

   always_ff @(posedge mclk)
   begin
      if (!rst_n)
      begin
         st_r <= lsq_pkg::ST_IDLE;
         fill_left_r <= '0;
         fill_val_r <= '0;
         run_idx_r <= '0;
         us_left_r <= '0;
         level_r <= '0;
         lvl_dummy <= 1'b0;
      end
      else
      begin
         lvl_dummy <= st_r == lsq_pkg::ST_RUN;
         unique case (st_r)
            lsq_pkg::ST_IDLE:
               if (cmd_ok && samp_op)
               begin
                  st_r <= lsq_pkg::ST_FILL;
                  fill_left_r <= avg;
                  fill_val_r <= arg1_r[VW-1:0];
               end
               else if (run_go)
               begin
                  st_r <= lsq_pkg::ST_RUN;
                  run_idx_r <= '0;
                  level_r <= val_mem[0];
                  us_left_r <= dwl_mem[0];
               end
            lsq_pkg::ST_FILL:
            begin
               fill_left_r <= fill_left_r - 1'b1;
               if (fill_left_r == 9'h001)
                  st_r <= lsq_pkg::ST_IDLE;
            end
            lsq_pkg::ST_RUN:
               if (expire && run_idx_r == val_cnt_r - 1'b1)
                  st_r <= lsq_pkg::ST_IDLE;
               else if (expire)
               begin
                  run_idx_r <= run_idx_r + 1'b1;
                  level_r <= val_mem[run_idx_r + 1'b1];
                  us_left_r <= dwl_cnt_r == AW'(1) ? dwl_mem[0] :
                     dwl_mem[run_idx_r + 1'b1];
               end
               else if (tick)
                  us_left_r <= us_left_r - 1'b1;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Microsecond prescaler and trigger pulse timer
   always_ff @(posedge mclk)
   begin
      if (!rst_n)
      begin
         pre_r <= '0;
         pls_left_r <= '0;
      end
      else
      begin
         pre_r <= tick ? PW'(CYC_PER_US - 1) : pre_r - 1'b1;
         if ((run_go && trg_mem[0]) ||
             (expire && run_idx_r != val_cnt_r - 1'b1 &&
              trg_mem[run_idx_r + 1'b1]))
            pls_left_r <= trig_us_r;
         else if (tick && pls_left_r != '0)
            pls_left_r <= pls_left_r - 1'b1;
      end
   end

   // Flag transistor: pulse timing in trigger mode, else output-off
   always_ff @(posedge mclk)
   begin
      if (!rst_n)
      begin
         off_s1_r <= 1'b0;
         off_s2_r <= 1'b0;
         flag_r <= 1'b0;
      end
      else
      begin
         off_s1_r <= output_off;
         off_s2_r <= off_s1_r;
         if (trig_mode_r)
            flag_r <= pls_left_r != '0 ? trig_pol_r : !trig_pol_r;
         else
            flag_r <= off_s2_r;
      end
   end

   ////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_n);

   sequence s_samp_go;
      cmd_ok && samp_op && avg == `LSQ_AVG_MIN;
   endsequence
   sequence s_two_pts;
      vw_en && dw_en ##1 vw_en && dw_en ##1 !vw_en;
   endsequence

   chk_dwell_refuse: assert property (cmd_go && op == lsq_pkg::OP_DWELL &&
      st_r == lsq_pkg::ST_IDLE && arg0_r[15:0] < `LSQ_DWELL_MIN_US
      |-> push_code == `LSQ_E_CMD && !dw_en)
      else $error("short dwell accepted");
   chk_avg_pow2: assert property (cmd_ok && samp_op |=>
      $onehot(fill_left_r) && fill_left_r >= `LSQ_AVG_MIN)
      else $error("averaging count not a power of two");
   chk_samp_fill: assert property (s_samp_go |=> s_two_pts)
      else $error("sample fill length wrong");
   chk_no_duration: assert property (cmd_go && samp_op &&
      st_r == lsq_pkg::ST_IDLE && !samp_set_r |-> push_code == `LSQ_E_CONF)
      else $error("sample without duration not refused");
   chk_ninth_sample: assert property (cmd_go && samp_op && samp_set_r &&
      lstep_r && st_r == lsq_pkg::ST_IDLE && dwl_cnt_r == val_cnt_r &&
      32'(smp_cnt_r) == NSMP |-> push_code == `LSQ_E_MUCH)
      else $error("ninth sample accepted");
   chk_samp_once: assert property (cmd_go &&
      op == lsq_pkg::OP_SET_SAMP && samp_set_r |-> push_code == `LSQ_E_CMD
      ##1 samp_us_r == $past(samp_us_r))
      else $error("sample duration set twice");
   chk_trig_flag: assert property (trig_mode_r && pls_left_r != '0
      |=> flag_r == $past(trig_pol_r))
      else $error("flag state wrong during pulse");
   chk_point_step: assert property (vw_en && !cmd_ok |=>
      val_cnt_r == $past(val_cnt_r) + 1'b1)
      else $error("value pointer did not advance");
   chk_err_fifo: assert property (push && eq_n_r == '0 |=>
      eq_n_r == QW'(1) && eq_mem[eq_rp_r] == $past(push_code))
      else $error("error queue order broken");

endmodule // lsq_sequencer

// ### lsq_out_stage.sv
`timescale 1ns/1ps
// Output stage model: off status changes on its own schedule
module lsq_out_stage (
   // Clock
   input wire logic mclk,
   // Status to the sequencer
   output logic output_off
);
   int n = 0;
   // Toggle status every 37 cycles
   always @(posedge mclk)
   begin
      n <= n + 1;
      output_off <= n % 74 < 37;
   end
endmodule // lsq_out_stage

// ### tb.sv
`timescale 1ns/1ps
`include "lsq_map.svh"
`define CHK(n, x, y) begin comparisons++; if ((x) !== (y)) begin \
 err_count++; $display("wrong value %s exp %h got %h", n, x, y); end end
module tb;
   logic mclk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0;
   logic [11:0] paddr = 0;
   logic [31:0] pwdata = 0, prdata;
   logic pready, pslverr, list_running, flag_collector_on, output_off;
   logic [15:0] level_out, v, lv, lv_e, lvl_prev;
   logic [15:0] lvl_q[$];
   logic [32:0] exp_q[$], ex;
   logic [2:0] off_d = 3'h0;
   logic fchk = 0, tmode = 0;
   int run_n = 0, lo_n = 0;
   int err_count = 0, comparisons = 0, cyc = 0, seed = 2632;
   lsq_sequencer #(.CYC_PER_US(4)) dut (.mclk, .rst_n, .psel, .penable,
      .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .output_off,
      .level_out, .list_running, .flag_collector_on);
   lsq_out_stage stage (.mclk, .output_off);
   ////////////////////////////////////////////////////////////////////
   task automatic close_out;
      if (err_count == 0 && comparisons > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   // One APB transfer, held until pready is sampled high
   task automatic xf(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge mclk);
      penable <= 1'b1;
      @(posedge mclk);
      while (pready !== 1'b1)
         @(posedge mclk);
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge mclk);
   endtask
   task automatic rd(input logic [11:0] a, input logic [31:0] e,
                     input logic s = 1'b0);
      exp_q.push_back({s, e});
      xf(1'b0, a, 32'h0);
   endtask
   task automatic er(input logic [15:0] e);
      rd(`LSQ_ERR, {16'hffff, e});
   endtask
   task automatic cmd(input lsq_pkg::lsq_op_t op, input logic [31:0] a0,
                      input logic [31:0] a1);
      xf(1'b1, `LSQ_ARG0, a0);
      xf(1'b1, `LSQ_ARG1, a1);
      xf(1'b1, `LSQ_CMD, {28'h0, op});
   endtask
   ////////////////////////////////////////////////////////////////////
   // Clock
   initial
   begin
      forever #4 mclk = ~mclk;
   end
   // Output monitor: read notes, level notes, flag follow and run counts
   always @(posedge mclk)
   begin
      if (psel && penable && pready === 1'b1 && !pwrite && exp_q.size())
      begin
         ex = exp_q.pop_front();
         `CHK("prdata", ex, {pslverr, prdata})
      end
      if (rst_n && level_out !== lvl_prev)
      begin
         lv_e = lvl_q.pop_front();
         `CHK("level_out", lv_e, level_out)
      end
      lvl_prev <= level_out;
      off_d <= {off_d[1:0], output_off};
      if (fchk)
         `CHK("flag", off_d[2], flag_collector_on)
      run_n <= run_n + (list_running === 1'b1);
      lo_n <= lo_n + (tmode && flag_collector_on !== 1'b1);
   end
   // Hang guard
   always @(posedge mclk)
   begin
      cyc <= cyc + 1;
      if (cyc == 20000)
      begin
         err_count++;
         close_out();
      end
   end
   // Main sequence
   initial
   begin
      v = 16'($random(seed)) & 16'h7fff;
      lv = v | 16'h8000;
      repeat (4) @(posedge mclk);
      rst_n <= 1'b1;
      @(posedge mclk);
      rd(`LSQ_RES, 32'h0000_0f5d);
      rd(`LSQ_RBND, 32'h84d0_005d);
      fchk <= 1'b1;
      rd(`LSQ_WAIT, 32'h0);
      rd(12'h038, 32'h0, 1'b1);
      xf(1'b0, `LSQ_SDUR, 32'h0);
      er(`LSQ_E_CMD);
      xf(1'b0, `LSQ_TRIG, 32'h0);
      er(`LSQ_E_CMD);
      cmd(lsq_pkg::OP_DWELL, 92, 0);
      cmd(lsq_pkg::OP_DWELL, 34001, 0);
      cmd(lsq_pkg::OP_DWELL, 93, 0);
      cmd(lsq_pkg::OP_DWELL, 34000, 0);
      er(`LSQ_E_CMD);
      er(`LSQ_E_CMD);
      rd(`LSQ_DPTS, 32'h2);
      cmd(lsq_pkg::OP_VOLT, {16'h0, v}, 0);
      cmd(lsq_pkg::OP_TRIG, 0, 0);
      cmd(lsq_pkg::OP_VOLT, 0, 0);
      xf(1'b1, `LSQ_CMD, 32'hf);
      cmd(lsq_pkg::OP_SAMP_V, 4, 0);
      er(`LSQ_E_CONF);
      er(`LSQ_E_CMD);
      er(`LSQ_E_CONF);
      rd(`LSQ_VPTS, 32'h2);
      rd(12'h040, {16'h0, v});
      cmd(lsq_pkg::OP_SET_SAMP, 249, 0);
      cmd(lsq_pkg::OP_SET_SAMP, 250, 0);
      cmd(lsq_pkg::OP_SET_SAMP, 250, 0);
      er(`LSQ_E_CMD);
      er(`LSQ_E_CMD);
      cmd(lsq_pkg::OP_SET_SAMP, 250, 0);
      er(`LSQ_E_CMD);
      rd(`LSQ_SDUR, 32'hfa);
      cmd(lsq_pkg::OP_VOLT, 0, 0);
      cmd(lsq_pkg::OP_SAMP_V, 2, 0);
      er(`LSQ_E_LEN);
      cmd(lsq_pkg::OP_DWELL, 93, 0);
      cmd(lsq_pkg::OP_DWELL, 93, 0);
      cmd(lsq_pkg::OP_VOLT, 0, 0);
      cmd(lsq_pkg::OP_SAMP_V, 3, 0);
      rd(`LSQ_VPTS, 32'h6);
      rd(`LSQ_SCNT, 32'h5601);
      rd(12'h080, 32'h3);
      fchk <= 1'b0;
      cmd(lsq_pkg::OP_SET_TRIG, 250, 1);
      rd(`LSQ_TRIG, 32'h1_00fa);
      cmd(lsq_pkg::OP_CLEAR, 0, 0);
      fchk <= 1'b1;
      cmd(lsq_pkg::OP_SET_WAIT, 300, 0);
      rd(`LSQ_WAIT, 32'h12c);
      xf(1'b1, `LSQ_RES, 32'h1);
      rd(`LSQ_RES, 32'h0001_170c);
      rd(`LSQ_RBND, 32'h005d_84d0);
      cmd(lsq_pkg::OP_DWELL, 93, 0);
      rd(`LSQ_VPTS, 32'h0);
      fchk <= 1'b0;
      cmd(lsq_pkg::OP_SET_TRIG, 250, 0);
      tmode <= 1'b1;
      cmd(lsq_pkg::OP_CURR, {16'h0, lv}, 0);
      cmd(lsq_pkg::OP_TRIG, {16'h0, v}, 0);
      rd(12'h040, {16'h0, lv});
      er(`LSQ_E_CONF);
      lvl_q.push_back(lv);
      lvl_q.push_back(v);
      cmd(lsq_pkg::OP_RUN, 0, 0);
      xf(1'b1, `LSQ_CMD, 32'h0);
      er(`LSQ_E_CMD);
      wait (list_running === 1'b0);
      repeat (700) @(posedge mclk);
      // Two steps of 93 us at 4 cycles per us; pulse of 250 us
      `CHK("run_len", 1'b1, run_n >= 741 && run_n <= 744)
      `CHK("pulse_len", 1000, lo_n)
      `CHK("levels", 0, lvl_q.size())
      rd(`LSQ_ERR, 32'h0);
      close_out();
   end
endmodule // tb
